// >>> rtl/pgp_pkg.sv
/*
 * Shared constants and carrier types for the port 2 / port 4 GPIO block.
 * Assumes an APB slave with byte addresses on paddr[7:0] and 32-bit data.
 */
package pgp_pkg;

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
localparam logic [7:0] A_P2_LATCH = 8'h00;
localparam logic [7:0] A_P2_DIR = 8'h04;
localparam logic [7:0] A_P4_LATCH = 8'h08;
localparam logic [7:0] A_P4_DIR = 8'h0C;
localparam logic [7:0] A_PULLUP = 8'h10;
localparam logic [7:0] A_OTYPE_B = 8'h14;
localparam logic [7:0] A_KRM = 8'h18;
localparam logic [7:0] A_P2_PIN = 8'h1C;
localparam logic [7:0] A_P4_PIN = 8'h20;
localparam logic [7:0] A_INT_STAT = 8'h24;
localparam logic [7:0] A_INT_MASK = 8'h28;
localparam logic [7:0] A_DIR_BIT = 8'h2C;

////////////////////////////////////////////////////////////////////////////////
// reset values
localparam logic [7:0] DIR_RST = 8'hFF;
localparam logic [7:0] LATCH_RST = 8'h00;
localparam logic [7:0] CFG_RST = 8'h00;
localparam logic [1:0] MASK_RST = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// field positions
localparam int PU_P2_BIT = 0;
localparam int PU_P4_BIT = 1;
localparam int OT_LO_PIN = 5;
localparam int OT_HI_PIN = 6;
localparam int INT_EXT = 0;
localparam int INT_KEY = 1;
localparam int DB_PORT_BIT = 3;
localparam int DB_VAL_BIT = 4;
localparam int SCK_PIN = 0;
localparam int SO_PIN = 1;
localparam int SI_PIN = 2;
localparam int TMR_PIN = 6;
localparam int SYNC_STAGES = 2;

////////////////////////////////////////////////////////////////////////////////
// carriers
typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
} pgp_pad_s;

typedef struct packed {
    logic sck_en;
    logic sck;
    logic so_en;
    logic so;
    logic to_en;
    logic to;
} pgp_alt_s;

endpackage : pgp_pkg

// >>> rtl/pgp_sync.sv
/*
 * Two-flop synchroniser for a bus of pin inputs.
 * Assumes inputs are asynchronous to clk; each bit is treated on its own.
 */
`timescale 1ns/10ps
module pgp_sync #(
    parameter int W = 8
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] d, // raw pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_r;

    initial begin
        if (W < 1) $error("pgp_sync: W must be at least 1");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pgp_sync

// >>> rtl/pgp_top.sv
/*
 * GPIO logic for port 2 (7 pins, shared functions) and port 4 (8 pins,
 * key return) behind an APB slave, with a sticky interrupt status.
 * Assumes pads resolve o/oe/pu externally and inputs are asynchronous.
 */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps

// Functional notes
// - Port 2 has seven pins, an output latch and per-bit direction.
// - Port 2 pull-ups are enabled as one group by the pull-up option register.
// - Pins 5 and 6 of port 2 each select push-pull or open-drain.
// - Reset puts every port 2 pin in input mode.
// - Port 2 pins are shared with serial, timer and external interrupt.
// - Port 4 has eight pins, an output latch and per-bit direction.
// - Port 4 pull-ups are enabled as one group of eight.
// - Port 4 pins serve as key-return inputs once the mode register is set.
// - Reset puts every port 4 pin in input mode.
// - Each direction register resets to all ones.
// - Direction registers take single-bit and whole-byte writes independently.
// - A level change on port 2 pin 6 in output mode sets its interrupt flag.
module pgp_top import pgp_pkg::*; #(
    parameter int P2_W = 7,
    parameter int P4_W = 8
) (
    input wire logic pclk, // apb clock, 40 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [P2_W-1:0] p2_in, // port 2 pin levels
    output pgp_pad_s p2_pad, // port 2 pad controls
    input wire logic [P4_W-1:0] p4_in, // port 4 pin levels
    output pgp_pad_s p4_pad, // port 4 pad controls
    input wire pgp_alt_s alt_i, // shared function outputs
    output logic sck_in, // serial clock from pin
    output logic si_in, // serial data from pin
    output logic tmr_in, // timer / ext interrupt from pin
    output logic irq // level interrupt
);
    localparam logic [7:0] P2_MASK = 8'((1 << P2_W) - 1);
    localparam logic [7:0] P4_MASK = 8'((1 << P4_W) - 1);
    localparam logic [1:0] ARM_DONE = 2'(SYNC_STAGES + 1);

    initial begin
        if (P2_W < 7 || P2_W > 8) $error("pgp_top: P2_W must be 7 or 8");
        if (P4_W < 1 || P4_W > 8) $error("pgp_top: P4_W must be 1 to 8");
    end

    logic [7:0] p2_lat_r, p2_dir_r, p4_lat_r, p4_dir_r;
    logic [1:0] pu_r, stat_r, stat_nxt, mask_r, evt;
    logic [7:0] otype_r, krm_r;
    logic [7:0] p2_s, p4_s, p4_prev_r;
    logic tmr_prev_r;
    logic [P2_W-1:0] p2_sq;
    logic [P4_W-1:0] p4_sq;
    logic acc, wr_en;
    logic [7:0] wb;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic [7:0] p2_drv;
    pgp_pad_s p2_nxt, p4_nxt;
    logic [1:0] arm_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, all answers registered
    assign acc = psel && penable;
    assign wr_en = acc && pready && pwrite && pstrb[0];
    assign wb = pwdata[7:0];

    always_comb begin
        rd_nxt = '0;
        err_nxt = 1'b0;
        unique case (paddr)
            A_P2_LATCH: rd_nxt[7:0] = p2_lat_r;
            A_P2_DIR: rd_nxt[7:0] = p2_dir_r;
            A_P4_LATCH: rd_nxt[7:0] = p4_lat_r;
            A_P4_DIR: rd_nxt[7:0] = p4_dir_r;
            A_PULLUP: rd_nxt[1:0] = pu_r;
            A_OTYPE_B: rd_nxt[7:0] = otype_r;
            A_KRM: rd_nxt[7:0] = krm_r;
            A_P2_PIN: rd_nxt[7:0] = p2_s;
            A_P4_PIN: rd_nxt[7:0] = p4_s;
            A_INT_STAT: rd_nxt[1:0] = stat_r;
            A_INT_MASK: rd_nxt[1:0] = mask_r;
            A_DIR_BIT: rd_nxt = '0;
            default: err_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc && !pready;
            if (acc && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
                pslverr <= err_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction registers: byte write or single-bit write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_dir_r <= DIR_RST;
            p4_dir_r <= DIR_RST;
        end else if (wr_en) begin
            if (paddr == A_P2_DIR) p2_dir_r <= wb;
            if (paddr == A_P4_DIR) p4_dir_r <= wb;
            if (paddr == A_DIR_BIT) begin
                if (wb[DB_PORT_BIT]) begin
                    p4_dir_r[wb[2:0]] <= wb[DB_VAL_BIT];
                end else begin
                    p2_dir_r[wb[2:0]] <= wb[DB_VAL_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latches and configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_lat_r <= LATCH_RST;
            p4_lat_r <= LATCH_RST;
            pu_r <= CFG_RST[1:0];
            otype_r <= CFG_RST;
            krm_r <= CFG_RST;
            mask_r <= MASK_RST;
        end else if (wr_en) begin
            unique case (paddr)
                A_P2_LATCH: p2_lat_r <= wb & P2_MASK;
                A_P4_LATCH: p4_lat_r <= wb & P4_MASK;
                A_PULLUP: pu_r <= wb[1:0];
                A_OTYPE_B: begin
                    otype_r[OT_LO_PIN] <= wb[OT_LO_PIN];
                    otype_r[OT_HI_PIN] <= wb[OT_HI_PIN];
                end
                A_KRM: krm_r <= wb & P4_MASK;
                A_INT_MASK: mask_r <= wb[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchronisers
    pgp_sync #(.W(P2_W)) u_p2_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(p2_in),
        .q(p2_sq)
    );

    pgp_sync #(.W(P4_W)) u_p4_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(p4_in),
        .q(p4_sq)
    );

    assign p2_s = 8'(p2_sq);
    assign p4_s = 8'(p4_sq);
    assign sck_in = p2_s[SCK_PIN];
    assign si_in = p2_s[SI_PIN];
    assign tmr_in = p2_s[TMR_PIN];

    ////////////////////////////////////////////////////////////////////////////
    // pad drive: latch or shared function, push-pull or open-drain
    always_comb begin
        p2_drv = p2_lat_r;
        if (alt_i.sck_en) p2_drv[SCK_PIN] = alt_i.sck;
        if (alt_i.so_en) p2_drv[SO_PIN] = alt_i.so;
        if (alt_i.to_en) p2_drv[TMR_PIN] = alt_i.to;
    end

    for (genvar i = 0; i < 8; i++) begin : g_pad
        logic od;
        assign od = (i == OT_LO_PIN || i == OT_HI_PIN) && otype_r[i];
        assign p2_nxt.o[i] = P2_MASK[i] && p2_drv[i];
        assign p2_nxt.oe[i] = P2_MASK[i] && !p2_dir_r[i] && (!od || !p2_drv[i]);
        assign p2_nxt.pu[i] = P2_MASK[i] && p2_dir_r[i] && pu_r[PU_P2_BIT];
        assign p4_nxt.o[i] = P4_MASK[i] && p4_lat_r[i];
        assign p4_nxt.oe[i] = P4_MASK[i] && !p4_dir_r[i];
        assign p4_nxt.pu[i] = P4_MASK[i] && p4_dir_r[i] && pu_r[PU_P4_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_pad <= '0;
            p4_pad <= '0;
        end else begin
            p2_pad <= p2_nxt;
            p4_pad <= p4_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events: pin 6 rising edge or output change, key-return falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_prev_r <= 1'b0;
            p4_prev_r <= '0;
        end else begin
            tmr_prev_r <= p2_s[TMR_PIN];
            p4_prev_r <= p4_s;
        end
    end

    // synchronisers leave reset at 0: hold off input edges until they carry pin levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_r <= '0;
        end else if (arm_r != ARM_DONE) begin
            arm_r <= arm_r + 2'h1;
        end
    end

    assign evt[INT_EXT] = (!p2_dir_r[TMR_PIN] && p2_nxt.o[TMR_PIN] != p2_pad.o[TMR_PIN])
        || (p2_dir_r[TMR_PIN] && p2_s[TMR_PIN] && !tmr_prev_r && arm_r == ARM_DONE);
    assign evt[INT_KEY] = |(krm_r & p4_prev_r & ~p4_s);

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear, set wins
    always_comb begin
        stat_nxt = stat_r;
        if (wr_en && paddr == A_INT_STAT) stat_nxt = stat_nxt & ~wb[1:0];
        stat_nxt = stat_nxt | evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
            irq <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq <= |(stat_nxt & ~mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_dir_byte(logic [7:0] a);
        wr_en && paddr == a;
    endsequence

    sequence s_p6_out_change;
        !$past(p2_dir_r[TMR_PIN]) && $changed(p2_pad.o[TMR_PIN]);
    endsequence

    a_dir_reset_ones: assert property ($rose(presetn) |-> p2_dir_r == 8'hFF && p4_dir_r == 8'hFF)
        else $error("direction register not all ones after reset");
    a_p2_reset_input: assert property ($rose(presetn) |-> p2_pad.oe == 8'h00 ##1 p2_pad.oe == 8'h00)
        else $error("port 2 drives a pin after reset");
    a_p4_reset_input: assert property ($rose(presetn) |-> p4_pad.oe == 8'h00 ##1 p4_pad.oe == 8'h00)
        else $error("port 4 drives a pin after reset");
    a_dir_byte_write: assert property (s_dir_byte(A_P4_DIR) |=> p4_dir_r == $past(wb))
        else $error("port 4 direction byte write lost");
    a_dir_bit_write: assert property (s_dir_byte(A_DIR_BIT) && !wb[DB_PORT_BIT]
        |=> p2_dir_r[$past(wb[2:0])] == $past(wb[DB_VAL_BIT]))
        else $error("port 2 direction bit write lost");
    a_out_from_latch: assert property (!p4_dir_r[3] |=> p4_pad.oe[3] && p4_pad.o[3] == $past(p4_lat_r[3]))
        else $error("port 4 output mode not driven from latch");
    a_pullup_p2_group: assert property (p2_dir_r[6:0] == 7'h7F && pu_r[PU_P2_BIT]
        |=> p2_pad.pu[6:0] == 7'h7F)
        else $error("port 2 pull-up group not applied");
    a_pullup_p4_group: assert property (p4_dir_r == 8'hFF && pu_r[PU_P4_BIT] |=> p4_pad.pu == P4_MASK)
        else $error("port 4 pull-up group not applied");
    a_open_drain_pin: assert property (!p2_dir_r[OT_LO_PIN] && otype_r[OT_LO_PIN]
        |=> !(p2_pad.oe[OT_LO_PIN] && p2_pad.o[OT_LO_PIN]))
        else $error("open-drain pin drives high");
    a_pin6_out_flag: assert property (s_p6_out_change |-> stat_r[INT_EXT])
        else $error("pin 6 output change did not set flag");
    a_key_return_flag: assert property (krm_r[0] && p4_prev_r[0] && !p4_s[0] |=> stat_r[INT_KEY])
        else $error("key-return edge did not set flag");
    a_alt_so_drive: assert property (alt_i.so_en && !p2_dir_r[SO_PIN]
        |=> p2_pad.o[SO_PIN] == $past(alt_i.so) && p2_pad.oe[SO_PIN])
        else $error("serial output not routed to pin");
    a_apb_one_wait: assert property (acc && !pready |=> pready ##1 !pready)
        else $error("apb answer not after one wait state");
    // interrupt, bus, direction, pad and pin input checks
    a_irq_level: assert property (
        irq == |(stat_r & ~$past(mask_r)))
        else $error("irq does not follow unmasked status");
    a_stat_w1c: assert property (wr_en && paddr == A_INT_STAT && wb[INT_EXT] && !evt[INT_EXT]
        |=> !stat_r[INT_EXT])
        else $error("status bit not cleared by write of one");
    a_stat_set_wins: assert property (evt[INT_EXT]
        |=> stat_r[INT_EXT])
        else $error("pin 6 event lost");
    a_err_unmapped: assert property (acc && !pready && paddr[1:0] != 2'h0
        |=> pslverr)
        else $error("misaligned address not refused");
    a_prdata_write: assert property (acc && !pready && pwrite
        |=> prdata == 32'h0000_0000)
        else $error("read data not zero after write");
    a_p2_dir_byte: assert property (s_dir_byte(A_P2_DIR)
        |=> p2_dir_r == $past(wb))
        else $error("port 2 direction byte write lost");
    a_p4_dir_bit: assert property (s_dir_byte(A_DIR_BIT) && wb[DB_PORT_BIT]
        |=> p4_dir_r[$past(wb[2:0])] == $past(wb[DB_VAL_BIT]))
        else $error("port 4 direction bit write lost");
    a_strobe_ignored: assert property (acc && pready && pwrite && !pstrb[0] && paddr == A_P4_DIR
        |=> $stable(p4_dir_r))
        else $error("write without byte strobe took effect");
    a_p2_all_input: assert property (&p2_dir_r[6:0]
        |=> p2_pad.oe == 8'h00)
        else $error("port 2 drives in input mode");
    a_p2_latch_out: assert property (!p2_dir_r[SI_PIN]
        |=> p2_pad.oe[SI_PIN] && p2_pad.o[SI_PIN] == $past(p2_lat_r[SI_PIN]))
        else $error("port 2 output not driven from latch");
    a_od_drives_low: assert property (!p2_dir_r[OT_LO_PIN] && otype_r[OT_LO_PIN]
        && !p2_drv[OT_LO_PIN] |=> p2_pad.oe[OT_LO_PIN])
        else $error("open-drain pin does not drive low");
    a_alt_sck_drive: assert property (alt_i.sck_en
        |=> p2_pad.o[SCK_PIN] == $past(alt_i.sck))
        else $error("serial clock not routed to pin");
    a_sync_latency: assert property (arm_r == ARM_DONE
        |-> tmr_in == $past(p2_in[TMR_PIN], 2))
        else $error("pin 6 input not two cycles late");
    a_no_early_edge: assert property (arm_r != ARM_DONE && p2_dir_r[TMR_PIN]
        |-> !evt[INT_EXT])
        else $error("input edge taken before synchroniser filled");
    a_input_edge_flag: assert property (arm_r == ARM_DONE && p2_dir_r[TMR_PIN]
        && p2_s[TMR_PIN] && !tmr_prev_r |=> stat_r[INT_EXT])
        else $error("pin 6 rising edge did not set flag");
    a_key_set_flag: assert property (evt[INT_KEY]
        |=> stat_r[INT_KEY])
        else $error("key-return event lost");
    a_key_gate: assert property (evt[INT_KEY]
        |-> (krm_r & p4_prev_r) != 8'h00)
        else $error("key-return event on disabled pin");
endmodule : pgp_top

// >>> sim/pgp_pins.sv
/*
 * Pin-side model: resolves both ports' pad controls against external levels.
 * Assumes a driving pad or an enabled pull-up overrides the weak external part.
 */
`timescale 1ns/10ps
module pgp_pins import pgp_pkg::*; (
    input pgp_pad_s p2_pad, // port 2 pad controls
    input pgp_pad_s p4_pad, // port 4 pad controls
    input logic [6:0] ext2, // external level, port 2
    input logic [7:0] ext4, // external level, port 4
    output logic [6:0] p2_in, // resolved port 2 pins
    output logic [7:0] p4_in // resolved port 4 pins
);
    logic [7:0] l2;
    logic [7:0] l4;

    // pad drive wins, then pull-up, then external part
    assign l2 = (p2_pad.oe & p2_pad.o) | (~p2_pad.oe & p2_pad.pu)
        | (~p2_pad.oe & ~p2_pad.pu & {1'b0, ext2});
    assign l4 = (p4_pad.oe & p4_pad.o) | (~p4_pad.oe & p4_pad.pu)
        | (~p4_pad.oe & ~p4_pad.pu & ext4);
    assign p2_in = l2[6:0];
    assign p4_in = l4;
endmodule : pgp_pins

// >>> sim/test_port2_port4_gpio.sv
/*
 * Self-checking bench for pgp_top: APB master tasks, one task per scenario.
 * Assumes the pin model pgp_pins closes the loop from pads back to inputs.
 */
`timescale 1ns/10ps
module test_port2_port4_gpio import pgp_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, rerr, sck_in, si_in, tmr_in, irq;
    logic [6:0] p2_in, ext2 = 7'h7F;
    logic [7:0] p4_in, ext4 = 8'hFF;
    pgp_pad_s p2_pad, p4_pad;
    pgp_alt_s alt_i = '0;
    int bad_count = 0, samples_checked = 0;

    pgp_top pgp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .p2_in(p2_in), .p2_pad(p2_pad), .p4_in(p4_in),
        .p4_pad(p4_pad), .alt_i(alt_i), .sck_in(sck_in), .si_in(si_in), .tmr_in(tmr_in),
        .irq(irq));
    pgp_pins pgp_pins_inst (.p2_pad(p2_pad), .p4_pad(p4_pad), .ext2(ext2), .ext4(ext4),
        .p2_in(p2_in), .p4_in(p4_in));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) chk("pready", 0, 1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 0);
        chk($sformatf("reg %h", a), rdat, e);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(A_P2_DIR, 32'hFF);
        rd(A_P4_DIR, 32'hFF);
        chk("p2 oe", 32'(p2_pad.oe), 32'h00);
        chk("p4 oe", 32'(p4_pad.oe), 32'h00);
        rd(A_INT_MASK, 32'h03);
        rd(A_INT_STAT, 32'h00);
        $display("done reset");
    endtask : t_reset

    task automatic t_dir;
        wr(A_P2_LATCH, 32'h55);
        wr(A_P2_DIR, 32'h00);
        tick(1);
        chk("p2 oe", 32'(p2_pad.oe), 32'h7F);
        chk("p2 o", 32'(p2_pad.o), 32'h55);
        tick(3);
        rd(A_P2_PIN, 32'h55);
        wr(A_DIR_BIT, 32'h0B);
        wr(A_DIR_BIT, 32'h12);
        rd(A_P4_DIR, 32'hF7);
        rd(A_P2_DIR, 32'h04);
        wr(A_P4_LATCH, 32'h08);
        tick(1);
        chk("p4 oe", 32'(p4_pad.oe), 32'h08);
        chk("p4 o", 32'(p4_pad.o), 32'h08);
        pstrb <= 4'hE;
        wr(A_P4_DIR, 32'h00);
        pstrb <= 4'hF;
        rd(A_P4_DIR, 32'hF7);
        wr(A_P2_DIR, 32'hFF);
        wr(A_P4_DIR, 32'hFF);
        $display("done direction");
    endtask : t_dir

    task automatic t_pull;
        wr(A_PULLUP, 32'h01);
        tick(2);
        chk("p2 pu", 32'(p2_pad.pu), 32'h7F);
        chk("p4 pu", 32'(p4_pad.pu), 32'h00);
        wr(A_PULLUP, 32'h02);
        tick(2);
        chk("p4 pu", 32'(p4_pad.pu), 32'hFF);
        chk("p2 pu", 32'(p2_pad.pu), 32'h00);
        wr(A_PULLUP, 32'h00);
        $display("done pull-up");
    endtask : t_pull

    task automatic t_odrain;
        wr(A_OTYPE_B, 32'h20);
        wr(A_P2_LATCH, 32'h00);
        wr(A_P2_DIR, 32'h1F);
        tick(1);
        chk("p2 oe", 32'(p2_pad.oe), 32'h60);
        wr(A_P2_LATCH, 32'h60);
        tick(1);
        chk("p2 oe", 32'(p2_pad.oe), 32'h40);
        chk("p2 o", 32'(p2_pad.o), 32'h60);
        wr(A_P2_DIR, 32'hFF);
        wr(A_OTYPE_B, 32'h00);
        $display("done open drain");
    endtask : t_odrain

    task automatic t_alt;
        wr(A_P2_LATCH, 32'h00);
        wr(A_P2_DIR, 32'h7C);
        alt_i <= '{sck_en: 1'b1, sck: 1'b1, so_en: 1'b1, so: 1'b1, to_en: 1'b1, to: 1'b1};
        ext2[2] <= 1'b0;
        tick(2);
        chk("p2 o0", 32'(p2_pad.o[0]), 32'h1);
        chk("p2 o1", 32'(p2_pad.o[1]), 32'h1);
        chk("p2 oe1", 32'(p2_pad.oe[1]), 32'h1);
        chk("p2 o6", 32'(p2_pad.o[6]), 32'h1);
        chk("p2 oe6", 32'(p2_pad.oe[6]), 32'h0);
        tick(3);
        chk("sck_in", 32'(sck_in), 32'h1);
        chk("si_in", 32'(si_in), 32'h0);
        chk("tmr_in", 32'(tmr_in), 32'h1);
        alt_i <= '0;
        ext2[2] <= 1'b1;
        wr(A_P2_DIR, 32'hFF);
        $display("done shared pins");
    endtask : t_alt

    task automatic t_ext_int;
        wr(A_INT_MASK, 32'h03);
        wr(A_P2_LATCH, 32'h00);
        wr(A_P2_DIR, 32'h3F);
        tick(4);
        wr(A_INT_STAT, 32'h03);
        rd(A_INT_STAT, 32'h00);
        wr(A_P2_LATCH, 32'h40);
        tick(3);
        rd(A_INT_STAT, 32'h01);
        chk("irq masked", 32'(irq), 32'h0);
        wr(A_INT_MASK, 32'h02);
        tick(2);
        chk("irq", 32'(irq), 32'h1);
        wr(A_INT_STAT, 32'h01);
        tick(2);
        chk("irq clr", 32'(irq), 32'h0);
        wr(A_P2_DIR, 32'hFF);
        ext2[6] <= 1'b0;
        tick(4);
        wr(A_INT_STAT, 32'h01);
        rd(A_INT_STAT, 32'h00);
        ext2[6] <= 1'b1;
        tick(4);
        rd(A_INT_STAT, 32'h01);
        wr(A_INT_STAT, 32'h01);
        wr(A_INT_MASK, 32'h03);
        $display("done external interrupt");
    endtask : t_ext_int

    task automatic t_key;
        wr(A_KRM, 32'h01);
        wr(A_INT_MASK, 32'h01);
        wr(A_INT_STAT, 32'h03);
        ext4[1] <= 1'b0;
        tick(4);
        rd(A_INT_STAT, 32'h00);
        ext4[0] <= 1'b0;
        tick(4);
        rd(A_INT_STAT, 32'h02);
        chk("irq key", 32'(irq), 32'h1);
        ext4 <= 8'hFF;
        wr(A_INT_STAT, 32'h03);
        $display("done key return");
    endtask : t_key

    task automatic t_bad;
        apb(1'b1, 8'h30, 32'h0);
        chk("slverr", 32'(rerr), 32'h1);
        apb(1'b1, 8'h05, 32'h00);
        chk("slverr", 32'(rerr), 32'h1);
        rd(A_P2_DIR, 32'hFF);
        $display("done unmapped");
    endtask : t_bad

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tick(10);
        presetn <= 1'b1;
        tick(1);
        t_reset();
        t_dir();
        t_pull();
        t_odrain();
        t_alt();
        t_ext_int();
        t_key();
        t_bad();
        wrap_up();
    end

    initial begin
        tick(20000);
        bad_count++;
        wrap_up();
    end
endmodule : test_port2_port4_gpio
